// ### hdl/smx_handler.sv
/*
 * device-side set max address ext handler: task-file shadow,
 * command execution, identify words, access limit check.
 * assumes: classic wishbone master on clk; one command at a time.
 */
`timescale 1ns/1ps
`include "smx_map.svh"

// Contract
// R01: lba low reads max bits 7:0, or 31:24 with hob set.
// R02: lba mid reads max bits 15:8, or 39:32 with hob set.
// R03: lba high reads max bits 23:16, or 47:40 with hob set.
// R04: success: bsy clear, drdy set, df drq err clear.
// R05: abort when unsupported, above capacity, locked or frozen.
// R06: abort unless directly preceded by a good native max read.
// R07: second non-volatile setting since reset gives idnf.
// R08: error: bsy clear, drdy set, drq clear, err follows error bits.
// R09: host issues native max read right before, with drdy set.
// R10: after success, accesses above new max report idnf.
// R11: identify words 100 to 103 hold the new maximum.
// R12: host sends at most one non-volatile setting per reset.
// R13: failed command changes neither max nor identify words.
// R14: cylinder mode: keep 3,6,55,56; word 1 is min(cyl+1,16383).
// R15: cylinder mode: words 61:60 are w1 times w3 times w6.
// R16: cylinder mode: word 54 capped at 65535; 58:57 is w54*w55*w56.
// R17: lba mode: words 61:60 are new max plus one.
// R18: lba mode, large, no chs: geometry words go to zero.
// R19: lba mode, chs, small: word 1 is capacity over w3*w6, capped.
// R20: lba mode, chs, large: words 1 and 54 are 16383.
// R21: lba mode small: w54 is capacity over w55*w56; 58:57 product.
// R22: on error, count and lba outputs read as reserved zero.
// R23: sector count bit 0 picks whether the max survives reset.
// R24: 48-bit request from current and previous lba bytes, code 37h.
// R25: keep preceded flag and non-volatile setting flag.
module smx_handler #(
  parameter logic [47:0] NATIVE_MAX = 48'h0000_1fff_ffff,
  parameter bit HPA_SUPPORTED = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // power-on or hardware reset event, same clock
  input wire logic hard_reset_evt,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  smx_pkg::smx_state_t state;
  logic [7:0] seccnt, lo_cur, lo_prev, mid_cur, mid_prev, hi_cur, hi_prev;
  logic [7:0] device, command, devctl, config_r, status, error;
  logic [7:0] id_sel;
  logic [31:0] acc_lo;
  logic [15:0] acc_hi;
  logic acc_idnf;
  logic [47:0] max_addr, nv_max, result;
  logic res_ok, preceded, nv_done;
  logic [15:0] w1, w3, w6, w54, w55, w56;
  logic [31:0] w57, w60;
  logic [15:0] next_w1, next_w3, next_w6, next_w54, next_w55, next_w56;
  logic [31:0] next_w57, next_w60;
  logic [47:0] req, next_max;
  logic fail_abrt, fail_idnf;
  logic [15:0] rdata_w;
  logic [31:0] rdata;
  logic wr_go, rd_go, cmd_go;

  ////////////////////////////////////////////////////////////////////
  // bus decode
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_go = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign cmd_go = wr_go && wb_adr_i == `SMX_OFF_CMD
    && state == smx_pkg::SMX_IDLE;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;

  ////////////////////////////////////////////////////////////////////
  // task-file shadow; each lba write pushes the old byte back
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      seccnt <= 8'h00;
      lo_cur <= 8'h00;
      lo_prev <= 8'h00;
      mid_cur <= 8'h00;
      mid_prev <= 8'h00;
      hi_cur <= 8'h00;
      hi_prev <= 8'h00;
      device <= 8'h00;
      devctl <= 8'h00;
      config_r <= `SMX_RST_CONFIG;
      id_sel <= 8'h00;
      acc_lo <= 32'h0000_0000;
      acc_hi <= 16'h0000;
    end
    else if (wr_go)
      case (wb_adr_i)
        `SMX_OFF_SECCNT: seccnt <= wb_dat_i[7:0];
        `SMX_OFF_LBA_LO:
        begin
          lo_prev <= lo_cur; // [R24]
          lo_cur <= wb_dat_i[7:0];
        end
        `SMX_OFF_LBA_MID:
        begin
          mid_prev <= mid_cur; // [R24]
          mid_cur <= wb_dat_i[7:0];
        end
        `SMX_OFF_LBA_HI:
        begin
          hi_prev <= hi_cur; // [R24]
          hi_cur <= wb_dat_i[7:0];
        end
        `SMX_OFF_DEVICE: device <= wb_dat_i[7:0];
        `SMX_OFF_DEVCTL: devctl <= wb_dat_i[7:0];
        `SMX_OFF_CONFIG: config_r <= wb_dat_i[7:0];
        `SMX_OFF_ID_SEL: id_sel <= wb_dat_i[7:0];
        `SMX_OFF_ACC_LO: acc_lo <= wb_dat_i;
        `SMX_OFF_ACC_HI: acc_hi <= wb_dat_i[15:0];
        default: ;
      endcase

  assign req = {hi_prev, mid_prev, lo_prev, hi_cur, mid_cur, lo_cur}; // [R24]

  ////////////////////////////////////////////////////////////////////
  // new identify words and maximum for the pending request
  function automatic logic [31:0] quot(input logic [31:0] n,
    input logic [31:0] d);
    quot = (d == 32'h0) ? 32'h0 : n / d;
  endfunction : quot

  always_comb
  begin
    logic [31:0] q;
    logic [16:0] cyl;
    q = 32'h0;
    cyl = {1'b0, hi_cur, mid_cur} + 17'h1;
    next_w3 = w3;
    next_w6 = w6;
    next_w55 = w55;
    next_w56 = w56;
    if (!device[`SMX_DEV_LBA])
    begin
      next_w1 = (cyl > 17'(`SMX_CYL_LIMIT)) ? `SMX_CYL_LIMIT
        : cyl[15:0]; // [R14]
      next_w60 = 32'(next_w1 * w3 * w6); // [R15]
      q = quot((next_w60 < `SMX_CHS_THRESH) ? next_w60 : `SMX_CHS_THRESH,
        32'(w55 * w56));
      next_w54 = (q > `SMX_W54_LIMIT) ? 16'hffff : q[15:0]; // [R16]
      next_max = 48'(next_w60) - 48'h1;
    end
    else
    begin
      next_max = req;
      next_w60 = (req[47:32] != 16'h0) ? 32'hffff_ffff
        : req[31:0] + 32'h1; // [R17]
      if (next_w60 > `SMX_CHS_THRESH && !config_r[`SMX_CFG_CHS])
      begin
        next_w1 = 16'h0; // [R18]
        next_w3 = 16'h0;
        next_w6 = 16'h0;
        next_w54 = 16'h0;
        next_w55 = 16'h0;
        next_w56 = 16'h0;
      end
      else if (next_w60 >= `SMX_CHS_THRESH)
      begin
        next_w1 = `SMX_CYL_LIMIT; // [R20]
        next_w54 = `SMX_CYL_LIMIT;
      end
      else
      begin
        q = quot(next_w60, 32'(w3 * w6));
        next_w1 = (q > `SMX_W54_LIMIT) ? 16'hffff : q[15:0]; // [R19]
        q = quot(next_w60, 32'(w55 * w56));
        next_w54 = q[15:0]; // [R21]
      end
    end
    next_w57 = 32'(next_w54 * next_w55 * next_w56); // [R16] [R21]
  end

  // abort outranks idnf; both leave state untouched
  assign fail_abrt = !HPA_SUPPORTED || next_max > NATIVE_MAX // [R05]
    || config_r[`SMX_CFG_LOCKED] || config_r[`SMX_CFG_FROZEN]
    || !preceded; // [R06]
  assign fail_idnf = seccnt[`SMX_KEEP_BIT] && nv_done; // [R07]

  ////////////////////////////////////////////////////////////////////
  // command sequencer: one busy cycle per command
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      state <= smx_pkg::SMX_IDLE;
      command <= 8'h00;
    end
    else
      case (state)
        smx_pkg::SMX_IDLE:
          if (cmd_go)
          begin
            command <= wb_dat_i[7:0];
            state <= smx_pkg::SMX_EXEC;
          end
        smx_pkg::SMX_EXEC: state <= smx_pkg::SMX_IDLE;
        default: state <= smx_pkg::SMX_IDLE;
      endcase

  // status and error outputs, readback of the result
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      status <= `SMX_RST_STATUS;
      error <= 8'h00;
      result <= 48'h0;
      res_ok <= 1'b0;
      preceded <= 1'b0;
    end
    else if (cmd_go)
    begin
      status <= 8'h80;
      error <= 8'h00;
    end
    else if (state == smx_pkg::SMX_EXEC)
    begin
      preceded <= 1'b0;
      if (command == `SMX_CMD_READ_NATIVE)
      begin
        status <= `SMX_RST_STATUS;
        result <= NATIVE_MAX;
        res_ok <= 1'b1;
        preceded <= 1'b1; // [R25]
      end
      else if (command == `SMX_CMD_SET_MAX && !fail_abrt && !fail_idnf)
      begin
        status <= `SMX_RST_STATUS; // [R04]
        result <= next_max;
        res_ok <= 1'b1;
      end
      else
      begin
        status <= `SMX_RST_STATUS | 8'h01; // [R08]
        error <= (command != `SMX_CMD_SET_MAX || fail_abrt) ? 8'h04
          : 8'h10; // [R05] [R06] [R07]
        res_ok <= 1'b0; // [R22]
      end
    end

  ////////////////////////////////////////////////////////////////////
  // maximum, identify words and the once-per-reset flag
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      max_addr <= NATIVE_MAX;
      nv_max <= NATIVE_MAX;
      nv_done <= 1'b0;
      w1 <= `SMX_RST_W1;
      w3 <= `SMX_RST_W3;
      w6 <= `SMX_RST_W6;
      w54 <= `SMX_RST_W1;
      w55 <= `SMX_RST_W3;
      w56 <= `SMX_RST_W6;
      w57 <= 32'(`SMX_RST_W1 * `SMX_RST_W3 * `SMX_RST_W6);
      w60 <= (NATIVE_MAX[47:32] != 16'h0) ? 32'hffff_ffff
        : NATIVE_MAX[31:0] + 32'h1;
    end
    else if (state == smx_pkg::SMX_EXEC && command == `SMX_CMD_SET_MAX
      && !fail_abrt && !fail_idnf) // [R13]
    begin
      // a completing setting outranks a reset event in the same cycle
      max_addr <= next_max; // [R11]
      if (seccnt[`SMX_KEEP_BIT])
      begin
        nv_max <= next_max; // [R23]
        nv_done <= 1'b1; // [R25]
      end
      else if (hard_reset_evt)
        nv_done <= 1'b0; // [R25]
      w1 <= next_w1;
      w3 <= next_w3;
      w6 <= next_w6;
      w54 <= next_w54;
      w55 <= next_w55;
      w56 <= next_w56;
      w57 <= next_w57;
      w60 <= next_w60;
    end
    else if (hard_reset_evt)
    begin
      // volatile settings fall back; geometry words are kept
      max_addr <= nv_max; // [R23]
      nv_done <= 1'b0; // [R25]
    end

  // access limit probe, one cycle behind the address registers
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      acc_idnf <= 1'b0;
    else
      acc_idnf <= {acc_hi, acc_lo} > max_addr; // [R10]

  ////////////////////////////////////////////////////////////////////
  // read path
  always_comb
    case (id_sel)
      8'd1: rdata_w = w1;
      8'd3: rdata_w = w3;
      8'd6: rdata_w = w6;
      8'd54: rdata_w = w54;
      8'd55: rdata_w = w55;
      8'd56: rdata_w = w56;
      8'd57: rdata_w = w57[15:0];
      8'd58: rdata_w = w57[31:16];
      8'd60: rdata_w = w60[15:0];
      8'd61: rdata_w = w60[31:16];
      8'd100: rdata_w = max_addr[15:0]; // [R11]
      8'd101: rdata_w = max_addr[31:16];
      8'd102: rdata_w = max_addr[47:32];
      default: rdata_w = 16'h0;
    endcase

  always_comb
  begin
    logic hob;
    hob = devctl[`SMX_CTL_HOB];
    rdata = 32'h0;
    case (wb_adr_i)
      `SMX_OFF_LBA_LO: if (res_ok)
        rdata[7:0] = hob ? result[31:24] : result[7:0]; // [R01] [R22]
      `SMX_OFF_LBA_MID: if (res_ok)
        rdata[7:0] = hob ? result[39:32] : result[15:8]; // [R02]
      `SMX_OFF_LBA_HI: if (res_ok)
        rdata[7:0] = hob ? result[47:40] : result[23:16]; // [R03]
      `SMX_OFF_DEVICE: rdata[7:0] = device;
      `SMX_OFF_CMD: rdata[7:0] = status;
      `SMX_OFF_DEVCTL: rdata[7:0] = devctl;
      `SMX_OFF_ERROR: rdata[7:0] = error;
      `SMX_OFF_CONFIG: rdata[7:0] = config_r;
      `SMX_OFF_ID_SEL: rdata[7:0] = id_sel;
      `SMX_OFF_ID_DATA: rdata[15:0] = rdata_w;
      `SMX_OFF_ACC_LO: rdata = acc_lo;
      `SMX_OFF_ACC_HI: rdata[15:0] = acc_hi;
      `SMX_OFF_ACC_STAT: rdata[0] = acc_idnf;
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      wb_dat_o <= 32'h0;
    else if (rd_go)
      wb_dat_o <= rdata;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence set_exec_s;
    state == smx_pkg::SMX_EXEC && command == `SMX_CMD_SET_MAX;
  endsequence

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  busy_one_a: assert property (cmd_go |=> status[7] ##1 !status[7])
    else $error("busy not one cycle");
  ok_status_a: assert property ( // [R04]
    set_exec_s ##0 !fail_abrt && !fail_idnf |=> status == 8'h40)
    else $error("bad success status");
  abort_prec_a: assert property ( // [R06]
    set_exec_s ##0 !preceded |=> error[2] && status == 8'h41)
    else $error("missing abort");
  idnf_second_a: assert property ( // [R07]
    set_exec_s ##0 !fail_abrt && fail_idnf |=> error == 8'h10)
    else $error("missing idnf");
  err_flag_a: assert property ( // [R08]
    state == smx_pkg::SMX_IDLE |-> status[0] == (error != 8'h0))
    else $error("err bit mismatch");
  fail_keep_a: assert property ( // [R13]
    set_exec_s ##0 (fail_abrt || fail_idnf) && !hard_reset_evt
    |=> $stable(max_addr) && $stable(w60) && $stable(w1))
    else $error("failed command changed state");
  lo_read_a: assert property ( // [R01]
    rd_go && wb_adr_i == `SMX_OFF_LBA_LO && res_ok && !devctl[7]
    |=> wb_dat_o[7:0] == $past(result[7:0]))
    else $error("lba low readback wrong");
  reserved_a: assert property ( // [R22]
    rd_go && wb_adr_i == `SMX_OFF_LBA_HI && !res_ok |=> wb_dat_o == 32'h0)
    else $error("reserved output not zero");
  access_a: assert property ( // [R10]
    ({acc_hi, acc_lo} > max_addr) ##1 $stable(max_addr) |-> acc_idnf)
    else $error("access above max not flagged");
endmodule : smx_handler

// ### hdl/smx_map.svh
/*
 * offsets, field positions, reset values and limits of the
 * set-max-address-ext handler.
 * assumes: included by bare name; byte addresses on a 32-bit bus.
 */
`ifndef SMX_MAP_SVH
`define SMX_MAP_SVH
`define SMX_OFF_SECCNT 8'h00
`define SMX_OFF_LBA_LO 8'h04
`define SMX_OFF_LBA_MID 8'h08
`define SMX_OFF_LBA_HI 8'h0c
`define SMX_OFF_DEVICE 8'h10
`define SMX_OFF_CMD 8'h14
`define SMX_OFF_DEVCTL 8'h18
`define SMX_OFF_ERROR 8'h1c
`define SMX_OFF_CONFIG 8'h20
`define SMX_OFF_ID_SEL 8'h24
`define SMX_OFF_ID_DATA 8'h28
`define SMX_OFF_ACC_LO 8'h2c
`define SMX_OFF_ACC_HI 8'h30
`define SMX_OFF_ACC_STAT 8'h34
`define SMX_CMD_SET_MAX 8'h37
`define SMX_CMD_READ_NATIVE 8'h27
`define SMX_ST_BSY 7
`define SMX_ST_DRDY 6
`define SMX_ST_DF 5
`define SMX_ST_DRQ 3
`define SMX_ST_ERR 0
`define SMX_ER_IDNF 4
`define SMX_ER_ABRT 2
`define SMX_DEV_LBA 6
`define SMX_CTL_HOB 7
`define SMX_CFG_CHS 0
`define SMX_CFG_LOCKED 1
`define SMX_CFG_FROZEN 2
`define SMX_KEEP_BIT 0
`define SMX_CHS_THRESH 32'h00fb_fc10
`define SMX_CYL_LIMIT 16'h3fff
`define SMX_W54_LIMIT 32'h0000_ffff
`define SMX_RST_CONFIG 8'h01
`define SMX_RST_W1 16'h3fff
`define SMX_RST_W3 16'h0010
`define SMX_RST_W6 16'h003f
`define SMX_RST_STATUS 8'h40
`endif

// ### hdl/smx_pkg.sv
/*
 * types of the set-max-address-ext handler.
 * assumes: smx_map.svh holds all numbers.
 */
package smx_pkg;
  typedef enum logic [1:0] {
    SMX_IDLE = 2'b00,
    SMX_EXEC = 2'b01
  } smx_state_t;
endpackage : smx_pkg

// ### tb/smx_handler_bench.sv
/*
 * self-checking bench of smx_handler: corner and random set-max runs.
 * assumes: smx_host_model drives the bus; chs geometry 16 x 63.
 */
`timescale 1ns/1ps
module smx_handler_bench;
  localparam logic [47:0] NMAX = 48'h0000_1fff_ffff;
  localparam logic [31:0] TH = 32'h00fb_fc10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hard_reset_evt = 1'b0;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, q;
  logic [47:0] m, ma;
  logic [15:0] w;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 72109;

  always #4 clk = ~clk;

  smx_handler #(.NATIVE_MAX(NMAX)) smx_handler_inst (
    .clk(clk), .reset_n(reset_n), .hard_reset_evt(hard_reset_evt),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack));

  smx_host_model smx_host_model_inst (
    .clk(clk), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr),
    .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack));

  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    smx_host_model_inst.bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    smx_host_model_inst.bus(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic idw(input logic [7:0] n, input logic [15:0] e);
    wr(8'h24, {24'h0, n});
    rd(8'h28);
    chk(q, {16'h0, e});
  endtask : idw

  task automatic acc(input logic [47:0] a, input logic e);
    wr(8'h2c, a[31:0]);
    wr(8'h30, {16'h0, a[47:32]});
    rd(8'h34);
    chk(q, {31'h0, e});
  endtask : acc

  // lba low/mid/high are loaded after the native read, which reuses them
  task automatic set_max(input logic [47:0] a, input logic lba,
                         input logic keep, input logic pre);
    if (pre)
      smx_host_model_inst.issue(8'h27);
    smx_host_model_inst.load_lba(a);
    wr(8'h00, {31'h0, keep});
    wr(8'h10, {25'h0, lba, 6'h0});
    smx_host_model_inst.issue(8'h37);
  endtask : set_max

  task automatic ok_check(input logic [47:0] a);
    rd(8'h14);
    chk(q, 32'h40);
    rd(8'h1c);
    chk(q, 32'h0);
    for (int h = 0; h < 2; h++)
    begin
      wr(8'h18, {24'h0, h[0], 7'h0});
      for (int i = 0; i < 3; i++)
      begin
        rd(8'(4 + 4 * i));
        chk(q, {24'h0, a[8 * (i + 3 * h) +: 8]});
      end
    end
    wr(8'h18, 32'h0);
    for (int k = 0; k < 4; k++)
      idw(8'(100 + k), k < 3 ? a[16 * k +: 16] : 16'h0);
    acc(a + 48'h1, 1'b1);
    acc(a, 1'b0);
  endtask : ok_check

  task automatic err_check(input logic [31:0] e);
    rd(8'h14);
    chk(q, 32'h41);
    rd(8'h1c);
    chk(q, e);
    for (int i = 0; i < 3; i++)
    begin
      rd(8'(4 + 4 * i));
      chk(q, 32'h0);
    end
  endtask : err_check

  // geometry expectation with words 3/6/55/56 still at 16 and 63
  task automatic geo(input logic [15:0] w1, input logic [31:0] c);
    logic [31:0] p;
    p = {16'h0, w1} * 32'd1008;
    idw(8'd1, w1);
    idw(8'd54, w1);
    idw(8'd60, c[15:0]);
    idw(8'd61, c[31:16]);
    idw(8'd57, p[15:0]);
    idw(8'd58, p[31:16]);
    idw(8'd3, 16'h0010);
    idw(8'd56, 16'h003f);
  endtask : geo

  task automatic lba_case(input logic [47:0] a);
    logic [31:0] c;
    c = a[31:0] + 32'h1;
    set_max(a, 1'b1, 1'b0, 1'b1);
    ok_check(a);
    geo(c < TH ? 16'(c / 32'd1008) : 16'h3fff, c);
  endtask : lba_case

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h14);
    chk(q, 32'h40);
    rd(8'h20);
    chk(q, 32'h1);
    rd(8'hfc);
    chk(q, 32'h0);
    set_max(48'h1000, 1'b1, 1'b0, 1'b0);
    err_check(32'h4);
    idw(8'd100, NMAX[15:0]);
    // an unknown command aborts and disarms a pending native read
    smx_host_model_inst.issue(8'h27);
    smx_host_model_inst.issue(8'hc6);
    err_check(32'h4);
    set_max(48'h1000, 1'b1, 1'b0, 1'b0);
    err_check(32'h4);
    lba_case(48'h3e7);
    lba_case(NMAX);
    lba_case(48'h00fb_fc0f);
    for (int i = 0; i < 4; i++)
    begin
      m = {16'h0, 32'($random(seed)) & 32'h1fff_ffff};
      lba_case(m);
    end
    set_max(NMAX + 48'h1, 1'b1, 1'b0, 1'b1);
    err_check(32'h4);
    acc(m, 1'b0);
    acc(m + 48'h1, 1'b1);
    for (int i = 1; i < 3; i++)
    begin
      wr(8'h20, 32'h1 | (32'h1 << i));
      set_max(48'h5, 1'b1, 1'b0, 1'b1);
      err_check(32'h4);
    end
    wr(8'h20, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      m = {24'h0, (i[0] ? 16'd20000 : 16'd100) + 16'(i), 8'h0};
      w = m[23:8] + 16'h1 < 16'h3fff ? m[23:8] + 16'h1 : 16'h3fff;
      set_max(m, 1'b0, 1'b0, 1'b1);
      ok_check({16'h0, {16'h0, w} * 32'd1008 - 32'h1});
      geo(w, {16'h0, w} * 32'd1008);
    end
    ma = {16'h0, 32'($random(seed)) & 32'h00ff_ffff} + 48'h10;
    set_max(ma, 1'b1, 1'b1, 1'b1);
    ok_check(ma);
    set_max(ma - 48'h7, 1'b1, 1'b0, 1'b1);
    ok_check(ma - 48'h7);
    // second keep-over-reset setting on purpose
    set_max(48'h77, 1'b1, 1'b1, 1'b1);
    err_check(32'h10);
    acc(ma - 48'h6, 1'b1);
    @(posedge clk);
    hard_reset_evt <= 1'b1;
    @(posedge clk);
    hard_reset_evt <= 1'b0;
    acc(ma + 48'h1, 1'b1);
    acc(ma, 1'b0);
    set_max(48'h77, 1'b1, 1'b1, 1'b1);
    rd(8'h14);
    chk(q, 32'h40);
    wr(8'h20, 32'h0);
    set_max(48'h0100_0000, 1'b1, 1'b0, 1'b1);
    foreach (m[i])
      if (i < 8)
        idw(8'(i == 0 ? 1 : i < 3 ? 3 * i : 54 + i - 3), 16'h0);
    conclude();
  end
endmodule : smx_handler_bench

// ### tb/smx_host_model.sv
/*
 * host model: classic wishbone master for the task-file registers.
 * assumes: one clock shared with the handler; handler answers with ack.
 */
`timescale 1ns/1ps
module smx_host_model (
  // clock
  input wire logic clk,
  // wishbone master
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack
);
  initial
  begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'h1;
    wb_dat_w <= d;
    // no limit of its own: only the bench timeout ends this wait
    do
      @(posedge clk);
    while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    // released lines must not keep looking valid
    wb_adr <= ~a;
    wb_dat_w <= ~d;
  endtask : bus

  // previous byte first, so it shifts behind the current one
  task automatic load_lba(input logic [47:0] m);
    logic [31:0] q;
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, 8'(4 + 4 * i), {24'h0, m[8 * (i + 3) +: 8]}, q);
      bus(1'b1, 8'(4 + 4 * i), {24'h0, m[8 * i +: 8]}, q);
    end
  endtask : load_lba

  task automatic issue(input logic [7:0] cmd);
    logic [31:0] s;
    s = 32'h80;
    while (s[7] || !s[6])
      bus(1'b0, 8'h14, 32'h0, s);
    bus(1'b1, 8'h14, {24'h0, cmd}, s);
  endtask : issue
endmodule : smx_host_model
